// ### rtl/tcx_pkg.sv
// Constants shared by the tape character transmitter and its unit timer.
// Assumes a 25 MHz core clock and a 32-bit Avalon-MM register port.
package tcx_pkg;

  // Clock and line timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned UNIT_NS_75 = 13333333;
  localparam int unsigned UNIT_NS_45 = 21978022;
  localparam int unsigned UNIT_CYC_75 = UNIT_NS_75 / CLK_PERIOD_NS;
  localparam int unsigned UNIT_CYC_45 = UNIT_NS_45 / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 20;
  localparam int unsigned CODE_W = 5;
  localparam int unsigned UNITS_PER_FRAME = 7;

  // Register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_CHAR = 5'h08;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] REG_IRQ_CLEAR = 5'h10;
  localparam logic [4:0] REG_IRQ_ENABLE = 5'h14;
  localparam logic [4:0] REG_COUNT = 5'h18;

  // Control fields
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_FREE = 1;
  localparam int unsigned CTRL_SLOW = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status fields
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_TAPE = 1;
  localparam int unsigned ST_TIGHT = 2;
  localparam int unsigned ST_MARK = 3;
  localparam int unsigned ST_READY = 4;
  localparam int unsigned ST_SLOW = 5;

  // Interrupt event bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_TAPE_OUT = 1;
  localparam int unsigned EV_TIGHT = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  typedef enum logic [1:0] {
    TCX_IDLE,
    TCX_START,
    TCX_CODE,
    TCX_STOP
  } tcx_state_t;

endpackage : tcx_pkg

// ### rtl/tcx_unit_timer.sv
// Unit timer: one-cycle tick at the end of every line unit.
// Assumes the caller holds enable low while idle to rewind the count.
`timescale 1ns/1ps
`default_nettype none
module tcx_unit_timer
  import tcx_pkg::*;
#(
  parameter int unsigned WIDTH = TIMER_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic [WIDTH-1:0] unit_cycles,
  // Result
  output logic tick
);

  logic [WIDTH-1:0] count;
  wire logic at_end;
  wire logic [WIDTH-1:0] next_count;

  assign at_end = (count >= unit_cycles - WIDTH'(1));
  assign next_count = at_end ? '0 : count + WIDTH'(1);
  assign tick = enable & at_end;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (!enable) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule : tcx_unit_timer
`default_nettype wire

// ### rtl/tcx_transmitter.sv
// Tape character transmitter: start-stop serializer with register port.
// Assumes tape sensor pins are synchronous to core_clk.
//
// Overview of operation
// - Cycles run only while run, tape present and tape slack all hold.
// - With no tape the transmitter halts instead of sending all marks.
// - A tight tape stops sending, and sending resumes when it clears.
// - Free-wheel disables feed, overrides tape sensing and stays idle.
// - Each cycle feeds the tape one character, never during sensing.
// - All five holes are sampled at once, a hole being a mark.
// - The sampled code is latched before the start unit and held.
// - Every frame opens with a spacing start unit.
// - The five latched elements follow, first through fifth.
// - A marking stop unit follows the fifth element and ends the cycle.
// - A whole frame spans seven units, start through stop.
// - The line changes only when the next unit differs from the last.
// - Marking and spacing outputs are driven as complements.
// - Frames follow back to back, the first starting at once on run.
// - The unit rate is 75 or 45.5 baud and is fixed while running.
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module tcx_transmitter
  import tcx_pkg::*;
#(
  parameter int unsigned FAST_UNIT_CYCLES = UNIT_CYC_75,
  parameter int unsigned SLOW_UNIT_CYCLES = UNIT_CYC_45
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Tape sensors
  input wire logic [CODE_W-1:0] tape_holes,
  input wire logic tape_present,
  input wire logic tape_tight,
  // Tape mechanism
  output logic tape_advance,
  output logic feed_engaged,
  output logic tape_sense_override,
  // Signal line
  output logic line_mark,
  output logic line_space,
  // Interrupt
  output logic irq
);

  // Registers
  logic [2:0] ctrl;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [CODE_W-1:0] code_latch;
  logic [31:0] char_count;
  logic ack;
  logic slow_rate;
  logic line_level;
  logic tape_seen;
  logic tight_seen;
  tcx_state_t state;
  logic [2:0] elem_idx;

  // Next values
  tcx_state_t next_state;
  logic [2:0] next_elem_idx;

  // Decode and control wires
  wire logic bus_req;
  wire logic wr_go;
  wire logic rd_go;
  wire logic sel_ctrl;
  wire logic sel_status;
  wire logic sel_char;
  wire logic sel_irq_st;
  wire logic sel_irq_clr;
  wire logic sel_irq_en;
  wire logic sel_count;
  wire logic [31:0] rd_mux;
  wire logic run_sel;
  wire logic free_wheel;
  wire logic chain_closed;
  wire logic unit_tick;
  wire logic start_frame;
  wire logic frame_done;
  wire logic busy;
  wire logic unit_value;
  wire logic [TIMER_W-1:0] unit_cycles;
  wire logic [IRQ_W-1:0] events;
  wire logic [IRQ_W-1:0] clr_mask;
  wire logic ctrl_wr;
  wire logic irq_en_wr;
  wire logic irq_clr_wr;
  wire logic free_next;
  wire logic elem_last;
  wire logic tape_fell;
  wire logic tight_rose;
  wire logic [5:0] status_bits;
  wire logic [IRQ_W-1:0] irq_pending;

  // Bus: one wait state, read data taken at the edge that raises ack, write taken at the ack edge
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack;
  assign wr_go = avs_write & ack & avs_byteenable[0];
  assign rd_go = avs_read & ~ack;

  assign sel_ctrl = (avs_address == REG_CTRL);
  assign sel_status = (avs_address == REG_STATUS);
  assign sel_char = (avs_address == REG_CHAR);
  assign sel_irq_st = (avs_address == REG_IRQ_STATUS);
  assign sel_irq_clr = (avs_address == REG_IRQ_CLEAR);
  assign sel_irq_en = (avs_address == REG_IRQ_ENABLE);
  assign sel_count = (avs_address == REG_COUNT);

  // Write strobes, each live only at the ack edge
  assign ctrl_wr = wr_go & sel_ctrl;
  assign irq_en_wr = wr_go & sel_irq_en;
  assign irq_clr_wr = wr_go & sel_irq_clr;

  // Status word assembled from the field positions
  assign status_bits[ST_BUSY] = busy;
  assign status_bits[ST_TAPE] = tape_present;
  assign status_bits[ST_TIGHT] = tape_tight;
  assign status_bits[ST_MARK] = line_level;
  assign status_bits[ST_READY] = chain_closed;
  assign status_bits[ST_SLOW] = slow_rate;

  assign rd_mux =
    sel_ctrl ? {29'h0, ctrl} :
    sel_status ? {26'h0, status_bits} :
    sel_char ? {27'h0, code_latch} :
    sel_irq_st ? {29'h0, irq_status} :
    sel_irq_en ? {29'h0, irq_enable} :
    sel_count ? char_count :
    32'h0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req & ~ack;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (rd_go) begin
      avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      irq_enable <= IRQ_RESET;
    end else if (ctrl_wr) begin
      ctrl <= avs_writedata[2:0];
    end else if (irq_en_wr) begin
      irq_enable <= avs_writedata[IRQ_W-1:0];
    end
  end

  // Lever positions: free-wheel overrides run
  assign free_wheel = ctrl[CTRL_FREE];
  assign run_sel = ctrl[CTRL_RUN] & ~free_wheel;

  // Series enable chain
  assign chain_closed = run_sel & tape_present &
    ~tape_tight;

  assign feed_engaged = ~free_wheel;
  assign tape_sense_override = free_wheel;

  // Free-wheel landing at this edge keeps a frame from starting
  assign free_next = ctrl_wr ? avs_writedata[CTRL_FREE] : free_wheel;

  // Rate locked at the first frame of a run
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      slow_rate <= 1'b0;
    end else if (state == TCX_IDLE) begin
      slow_rate <= ctrl[CTRL_SLOW];
    end
  end

  assign unit_cycles = slow_rate ? TIMER_W'(SLOW_UNIT_CYCLES) :
                                   TIMER_W'(FAST_UNIT_CYCLES);

  assign busy = (state != TCX_IDLE);

  // Unit timer rewinds while idle
  tcx_unit_timer #(
    .WIDTH(TIMER_W)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(busy),
    .unit_cycles(unit_cycles),
    .tick(unit_tick)
  );

  // Frame sequencing
  assign frame_done = (state == TCX_STOP) & unit_tick;
  assign elem_last = (elem_idx == 3'(CODE_W - 1));
  assign start_frame = chain_closed & ~free_next &
    ((state == TCX_IDLE) | frame_done);

  always_comb begin
    next_state = state;
    next_elem_idx = elem_idx;
    case (state)
      TCX_IDLE: begin
        if (start_frame) begin
          next_state = TCX_START;
        end
      end
      TCX_START: begin
        if (unit_tick) begin
          next_state = TCX_CODE;
          next_elem_idx = 3'h0;
        end
      end
      TCX_CODE: begin
        if (unit_tick) begin
          if (elem_last) begin
            next_state = TCX_STOP;
          end else begin
            next_elem_idx = elem_idx + 3'h1;
          end
        end
      end
      TCX_STOP: begin
        if (unit_tick) begin
          next_state = start_frame ? TCX_START :
                                     TCX_IDLE;
        end
      end
      default: begin
        next_state = TCX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= TCX_IDLE;
      elem_idx <= 3'h0;
    end else begin
      state <= next_state;
      elem_idx <= next_elem_idx;
    end
  end

  // Sample all holes at once and hold them for the frame
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      code_latch <= '0;
    end else if (start_frame) begin
      code_latch <= tape_holes;
    end
  end

  // Feed after the code is latched, one character per cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tape_advance <= 1'b0;
    end else begin
      tape_advance <= start_frame;
    end
  end

  // Unit to send in the current state
  assign unit_value =
    (state == TCX_START) ? 1'b0 :
    (state == TCX_CODE) ? code_latch[elem_idx] :
    1'b1;

  // Line changes only on a differing unit; idles marking
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      line_level <= 1'b1;
    end else if (unit_value != line_level) begin
      line_level <= unit_value;
    end
  end

  assign line_mark = line_level;
  assign line_space = ~line_level;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      char_count <= 32'h0;
    end else if (frame_done) begin
      char_count <= char_count + 32'h1;
    end
  end

  // Sensor edge history for events
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tape_seen <= 1'b0;
      tight_seen <= 1'b0;
    end else begin
      tape_seen <= tape_present;
      tight_seen <= tape_tight;
    end
  end

  // Edges of the sensor pins
  assign tape_fell = tape_seen & ~tape_present;
  assign tight_rose = ~tight_seen & tape_tight;

  assign events[EV_DONE] = frame_done;
  assign events[EV_TAPE_OUT] = run_sel & tape_fell;
  assign events[EV_TIGHT] = run_sel & tight_rose;

  assign clr_mask = irq_clr_wr ? avs_writedata[IRQ_W-1:0] :
                                             '0;

  // Sticky status; a new event wins over a clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_status <= IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~clr_mask) | events;
    end
  end

  // Level interrupt while any enabled event is pending
  assign irq_pending = irq_status & irq_enable;
  assign irq = |irq_pending;

endmodule : tcx_transmitter
`default_nettype wire

// ### testbench/tcx_assertions.sv
// Checker: line levels, feed interlock and frame timing.
// Assumes it is bound to tcx_transmitter.
`timescale 1ns/1ps
`default_nettype none
module tcx_assertions
  import tcx_pkg::*;
#(
  parameter int unsigned FAST_UNIT_CYCLES = 8,
  parameter int unsigned SLOW_UNIT_CYCLES = 13
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic tape_present,
  input wire logic tape_tight,
  input wire logic tape_advance,
  input wire logic feed_engaged,
  input wire logic tape_sense_override,
  input wire logic line_mark,
  input wire logic line_space
);
  localparam int unsigned CNT_MAX = 7 * SLOW_UNIT_CYCLES;
  int unsigned cnt;
  // Cycles since the last feed pulse, saturating at one slow frame
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt <= CNT_MAX;
    end else if (tape_advance) begin
      cnt <= 0;
    end else if (cnt < CNT_MAX) begin
      cnt <= cnt + 1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_line_compl: assert property (line_space != line_mark)
    else $error("line outputs not complementary");
  a_free_override: assert property (
    tape_sense_override != feed_engaged)
    else $error("override and feed disagree");
  a_free_idle: assert property (!feed_engaged |-> !tape_advance)
    else $error("feed in free-wheel");
  a_feed_single: assert property (tape_advance |=> !tape_advance)
    else $error("tape fed twice in a row");
  a_chain_closed: assert property (tape_advance |->
    $past(tape_present) && !$past(tape_tight)
    && $past(feed_engaged))
    else $error("frame started with chain open");
  a_start_space: assert property (
    tape_advance |=> !line_mark [*8])
    else $error("start unit not spacing");
  a_stop_mark: assert property (tape_advance |-> line_mark)
    else $error("frame not preceded by marking");
  a_frame_len: assert property (
    tape_advance |-> cnt >= 7*FAST_UNIT_CYCLES-1)
    else $error("frame shorter than seven units");
  a_line_hold: assert property ($changed(line_mark) |->
    cnt % FAST_UNIT_CYCLES == 0 || cnt % SLOW_UNIT_CYCLES == 0)
    else $error("line changed off a unit edge");
  c_frame: cover property (tape_advance ##1 !line_mark);
  c_slow: cover property (tape_advance && cnt == 7*SLOW_UNIT_CYCLES-1);
  c_free: cover property (!feed_engaged);
endmodule : tcx_assertions
`default_nettype wire

// ### testbench/tcx_line_rx.sv
// Line receiver model: decodes start-stop frames at mid-unit.
// Assumes unit_cyc equals the transmitter unit length.
`timescale 1ns/1ps
`default_nettype none
module tcx_line_rx (
  // Clock and line
  input wire logic core_clk,
  input wire logic line_mark,
  input wire logic [7:0] unit_cyc,
  // Decoded frame
  output logic [4:0] code,
  output logic framing_ok,
  output var int frames
);
  logic [4:0] bits;
  logic ok;
  initial begin
    code = 5'h00;
    framing_ok = 1'b0;
    frames = 0;
    forever begin
      @(negedge line_mark);
      repeat (unit_cyc / 2) @(posedge core_clk);
      ok = !line_mark;
      for (int i = 0; i < 5; i++) begin
        repeat (unit_cyc) @(posedge core_clk);
        bits[i] = line_mark;
      end
      repeat (unit_cyc) @(posedge core_clk);
      framing_ok = ok && line_mark;
      code = bits;
      frames++;
    end
  end
endmodule : tcx_line_rx
`default_nettype wire

// ### testbench/tcx_transmitter_tb_top.sv
// Bench: registers, frame content, interlock and line rates.
// Assumes the receiver model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tcx_transmitter_tb_top;
  import tcx_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00, tape_holes = 5'h00, rx_code;
  logic avs_read = 1'b0, avs_write = 1'b0, tape_present = 1'b1;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hf;
  logic [7:0] unit_cyc = 8'h08;
  logic avs_waitrequest, tape_tight = 1'b0, tape_advance, feed_engaged;
  logic tape_sense_override, line_mark, line_space, irq, rx_ok;
  int rx_frames, error_cnt = 0, checks_done = 0, adv_n = 0;
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (tape_advance === 1'b1) adv_n++;
  tcx_transmitter #(.FAST_UNIT_CYCLES(8), .SLOW_UNIT_CYCLES(13)) dut (
    .core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .tape_holes, .tape_present, .tape_tight, .tape_advance, .feed_engaged,
    .tape_sense_override, .line_mark, .line_space, .irq);
  tcx_line_rx u_rx (.core_clk, .line_mark, .unit_cyc, .code(rx_code),
    .framing_ok(rx_ok), .frames(rx_frames));
  task automatic test_done;
    $display("Errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rc
  // Measures cycles between two feed pulses
  task automatic gap(input int e);
    int n;
    for (n = 0; tape_advance !== 1'b1 && n < 300; n++) @(posedge core_clk);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (tape_advance !== 1'b1 && n < 300);
    chk(32'(n), 32'(e));
  endtask : gap
  task automatic t_regs;
    rc(REG_CTRL, 32'h0);
    rc(5'h1c, 32'h0);
    rc(REG_STATUS, 32'h0a);
    chk(32'(line_mark), 32'h1);
    avs_byteenable <= 4'h0;
    bus(1'b1, REG_CTRL, 32'h1);
    avs_byteenable <= 4'hf;
    rc(REG_CTRL, 32'h0);
    bus(1'b1, REG_IRQ_ENABLE, 32'h7);
    rc(REG_IRQ_ENABLE, 32'h7);
  endtask : t_regs
  task automatic t_fast;
    tape_holes <= 5'h0d;
    bus(1'b1, REG_CTRL, 32'h1);
    gap(56);
    chk(32'(rx_code), 32'h0d);
    tape_holes <= 5'h12;
    repeat (56) @(posedge core_clk);
    chk(32'(rx_code), 32'h0d);
    chk(32'(rx_ok), 32'h1);
    repeat (56) @(posedge core_clk);
    chk(32'(rx_code), 32'h12);
    bus(1'b1, REG_CTRL, 32'h0);
    repeat (120) @(posedge core_clk);
    rc(REG_COUNT, 32'(rx_frames));
    chk(32'(irq), 32'h1);
    bus(1'b1, REG_IRQ_CLEAR, 32'h7);
    @(posedge core_clk);
    chk(32'(irq), 32'h0);
  endtask : t_fast
  task automatic t_sensors;
    int n;
    bus(1'b1, REG_CTRL, 32'h1);
    tape_present <= 1'b0;
    repeat (80) @(posedge core_clk);
    n = adv_n;
    repeat (120) @(posedge core_clk);
    chk(32'(adv_n), 32'(n));
    rc(REG_IRQ_STATUS, 32'h2);
    tape_present <= 1'b1;
    tape_tight <= 1'b1;
    repeat (120) @(posedge core_clk);
    chk(32'(adv_n), 32'(n));
    tape_tight <= 1'b0;
    gap(56);
  endtask : t_sensors
  task automatic t_free;
    int n;
    bus(1'b1, REG_CTRL, 32'h3);
    repeat (100) @(posedge core_clk);
    n = adv_n;
    chk(32'(tape_sense_override), 32'h1);
    repeat (100) @(posedge core_clk);
    chk(32'(adv_n), 32'(n));
    bus(1'b1, REG_CTRL, 32'h1);
    @(posedge core_clk);
    chk(32'(feed_engaged), 32'h1);
    gap(56);
  endtask : t_free
  task automatic t_slow;
    bus(1'b1, REG_CTRL, 32'h0);
    repeat (100) @(posedge core_clk);
    unit_cyc <= 8'h0d;
    tape_holes <= 5'h15;
    bus(1'b1, REG_CTRL, 32'h5);
    gap(91);
    chk(32'(rx_code), 32'h15);
    rc(REG_CHAR, 32'h15);
  endtask : t_slow
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs;
    t_fast;
    t_sensors;
    t_free;
    t_slow;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    test_done;
  end
endmodule : tcx_transmitter_tb_top
bind tcx_transmitter tcx_assertions #(.FAST_UNIT_CYCLES(FAST_UNIT_CYCLES),
  .SLOW_UNIT_CYCLES(SLOW_UNIT_CYCLES)) u_chk (.core_clk, .rst_n,
  .tape_present, .tape_tight, .tape_advance, .feed_engaged,
  .tape_sense_override, .line_mark, .line_space);
`default_nettype wire
